// ==== rtl/liu_channel_alarm_interrupt_regs.sv ====
// eight-channel alarm status, enable, change latch and resistor select
// =====================================================================
`timescale 1ns/1ns
`include "liu_alarm_cfg.svh"
module liu_channel_alarm_interrupt_regs
  import liu_alarm_pkg::*;
#(
  parameter int unsigned CHANNELS = 8,
  parameter int unsigned PERSIST_CYCLES = `PERSIST_S * `CLK_HZ
)
(
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic [`ADDR_W-1:0] addr_i,
  input wire logic [`DATA_W-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [CHANNELS-1:0] driver_fault_i,
  input wire logic [CHANNELS-1:0] fifo_limit_i,
  input wire logic [CHANNELS-1:0] code_violation_i,
  input wire logic [CHANNELS-1:0] all_ones_seen_i,
  input wire logic [CHANNELS-1:0] signal_loss_i,
  input wire logic [CHANNELS-1:0] pattern_lock_i,
  input wire logic [CHANNELS-1:0] loop_up_code_i,
  input wire logic [CHANNELS-1:0] loop_down_code_i,
  output logic [`DATA_W-1:0] rdata_o,
  output logic [CHANNELS-1:0] irq_o,
  output logic [CHANNELS-1:0] remote_loop_o,
  output logic [2*CHANNELS-1:0] rx_resistor_sel_o
);
  initial
  begin
    if (CHANNELS < 1 || CHANNELS > 8)
      $error("channel count must be 1 to 8");
  end

  // =====================================================================
  // host access decode
  host_req_t req;
  assign req = '{addr: addr_i, wdata: wdata_i, wr: wr_i, rd: rd_i};

  function automatic logic hit(input logic [7:0] a, input logic [3:0] idx,
                               input int unsigned ch);
    hit = (a[`IDX_MSB:`IDX_LSB] == idx) &&
          (a[`CH_MSB:`CH_LSB] == 3'(ch)) && !a[`BIT_PAGE];
  endfunction

  wire logic [2:0] sel_ch = req.addr[`CH_MSB:`CH_LSB];
  wire logic [3:0] sel_idx = req.addr[`IDX_MSB:`IDX_LSB];
  wire logic sel_ok = !req.addr[`BIT_PAGE] && (32'(sel_ch) < CHANNELS);

  logic [`DATA_W-1:0] line_q [CHANNELS];
  logic [`DATA_W-1:0] en_q [CHANNELS];
  logic [`DATA_W-1:0] live_q [CHANNELS];
  logic [`DATA_W-1:0] chg_q [CHANNELS];
  logic [`DATA_W-1:0] rdata_q;
  logic [CHANNELS-1:0] irq_q;
  logic [CHANNELS-1:0] rloop_q;
  logic [2*CHANNELS-1:0] rxres_q;

  // =====================================================================
  // per-channel logic
  genvar g;
  generate
    for (g = 0; g < CHANNELS; g++)
    begin : gen_ch
      detect_t det;
      logic [`DATA_W-1:0] live_d, chg_d, delta;
      logic seen, rloop;
      wire logic wr_line = req.wr && hit(req.addr, `IDX_LINE_TEST, g);
      wire logic wr_en = req.wr && hit(req.addr, `IDX_IRQ_EN, g);
      wire logic rd_chg = req.rd && hit(req.addr, `IDX_CHANGE, g);

      assign det = '{driver_fault: driver_fault_i[g],
                     fifo_limit: fifo_limit_i[g],
                     code_violation: code_violation_i[g],
                     all_ones_seen: all_ones_seen_i[g],
                     signal_loss: signal_loss_i[g],
                     pattern_lock: pattern_lock_i[g]};

      loop_code_persist #(.PERSIST_CYCLES(PERSIST_CYCLES)) u_loop (
        .clk_i(clk_i),
        .reset_n_i(reset_n_i),
        .mode_i(line_q[g][`BIT_MODE_HI:`BIT_MODE_LO]),
        .up_code_i(loop_up_code_i[g]),
        .down_code_i(loop_down_code_i[g]),
        .loop_code_seen_o(seen),
        .remote_loop_o(rloop)
      );

      // live bits follow detectors directly, no latching, except bit 3, the loop timer's seen flag, held in auto mode
      assign live_d = {1'b0,
                       det.driver_fault,
                       det.fifo_limit,
                       det.code_violation,
                       seen,
                       det.all_ones_seen,
                       det.signal_loss,
                       det.pattern_lock};
      assign delta = live_d ^ live_q[g];
      // new changes win over the read clear
      assign chg_d = (rd_chg ? `RESET_BYTE : chg_q[g]) | delta;

      always_ff @(posedge clk_i or negedge reset_n_i)
      begin
        if (!reset_n_i)
        begin
          line_q[g] <= `RESET_BYTE;
          en_q[g] <= `RESET_BYTE;
          live_q[g] <= `RESET_BYTE;
          chg_q[g] <= `RESET_BYTE;
          irq_q[g] <= 1'b0;
          rloop_q[g] <= 1'b0;
          rxres_q[2*g +: 2] <= `RXRES_NONE;
        end
        else
        begin
          if (wr_line)
            line_q[g] <= req.wdata;
          if (wr_en)
            en_q[g] <= {1'b0, req.wdata[`ALARM_BITS-1:0]};
          live_q[g] <= live_d;
          chg_q[g] <= chg_d;
          // line stays up while any enabled change is pending
          irq_q[g] <= |(chg_d & en_q[g]);
          rloop_q[g] <= rloop;
          rxres_q[2*g +: 2] <= {line_q[g][`BIT_RXRES_HI],
                                line_q[g][`BIT_RXRES_LO]};
        end
      end
    end
  endgenerate

  // =====================================================================
  // read path, registered one cycle after the strobe
  logic [`DATA_W-1:0] rmux;
  always_comb
  begin
    rmux = `RESET_BYTE;
    if (sel_ok)
    begin
      unique case (sel_idx)
        `IDX_LINE_TEST: rmux = line_q[sel_ch];
        `IDX_IRQ_EN: rmux = en_q[sel_ch];
        `IDX_LIVE: rmux = live_q[sel_ch];
        `IDX_CHANGE: rmux = chg_q[sel_ch];
        default: rmux = `RESET_BYTE;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      rdata_q <= `RESET_BYTE;
    else if (req.rd)
      rdata_q <= rmux;
  end

  assign rdata_o = rdata_q;
  assign irq_o = irq_q;
  assign remote_loop_o = rloop_q;
  assign rx_resistor_sel_o = rxres_q;
endmodule

// ==== rtl/liu_alarm_cfg.svh ====
// address map, field positions, reset values and timing for the alarm block
`ifndef LIU_ALARM_CFG_SVH
`define LIU_ALARM_CFG_SVH
`define ADDR_W 8
`define DATA_W 8
`define CH_MSB 6
`define CH_LSB 4
`define IDX_MSB 3
`define IDX_LSB 0
`define BIT_PAGE 7
`define IDX_LINE_TEST 4'h3
`define IDX_IRQ_EN 4'h4
`define IDX_LIVE 4'h5
`define IDX_CHANGE 4'h6
`define RESET_BYTE 8'h00
`define ALARM_BITS 7
`define BIT_RXRES_HI 4
`define BIT_RXRES_LO 3
`define BIT_MODE_HI 7
`define BIT_MODE_LO 6
`define BIT_LOOP_CODE 3
`define MODE_OFF 2'h0
`define MODE_UP 2'h1
`define MODE_DOWN 2'h2
`define MODE_AUTO 2'h3
`define RXRES_NONE 2'h0
`define RXRES_240 2'h1
`define RXRES_210 2'h2
`define RXRES_150 2'h3
`define PERSIST_S 5
`define CLK_HZ 100000000
`endif

// ==== rtl/liu_alarm_pkg.sv ====
// types shared by the alarm block
package liu_alarm_pkg;
  typedef enum logic [1:0] {
    LOOP_OFF,
    LOOP_MANUAL,
    LOOP_AUTO_UP,
    LOOP_AUTO_DOWN
  } loop_state_t;
  typedef struct packed {
    logic driver_fault;
    logic fifo_limit;
    logic code_violation;
    logic all_ones_seen;
    logic signal_loss;
    logic pattern_lock;
  } detect_t;
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } host_req_t;
endpackage

// ==== rtl/loop_code_persist.sv ====
// per-channel loop code persistence timer and automatic loopback control
`timescale 1ns/1ns
`include "liu_alarm_cfg.svh"
module loop_code_persist
  import liu_alarm_pkg::*;
#(
  parameter int unsigned PERSIST_CYCLES = `PERSIST_S * `CLK_HZ
)
(
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic [1:0] mode_i,
  input wire logic up_code_i,
  input wire logic down_code_i,
  output logic loop_code_seen_o,
  output logic remote_loop_o
);
  initial
  begin
    if (PERSIST_CYCLES < 2)
      $error("persist count too small");
  end

  localparam int CW = $clog2(PERSIST_CYCLES + 1);
  loop_state_t state_q, state_d;
  logic [CW-1:0] cnt_q, cnt_d;
  logic [1:0] mode_q;
  logic seen_q, seen_d;
  logic loop_q, loop_d;

  // selected code for the current phase
  wire logic want_up = (mode_i == `MODE_UP) ||
    (state_q == LOOP_AUTO_UP);
  wire logic code_now = want_up ? up_code_i : down_code_i;
  // "over" five seconds: the count must reach the figure with the code still present
  wire logic persisted = (cnt_q == CW'(PERSIST_CYCLES));
  wire logic mode_change = (mode_i != mode_q);

  always_comb
  begin
    state_d = state_q;
    seen_d = seen_q;
    loop_d = loop_q;
    cnt_d = code_now ? (persisted ? cnt_q : cnt_q + 1'b1) : '0;
    if (mode_change)
    begin
      cnt_d = '0;
      seen_d = 1'b0;
      loop_d = 1'b0;
      unique case (mode_i)
        `MODE_OFF: state_d = LOOP_OFF;
        `MODE_AUTO: state_d = LOOP_AUTO_UP;
        default: state_d = LOOP_MANUAL;
      endcase
    end
    else
    begin
      unique case (state_q)
        LOOP_OFF:
        begin
          seen_d = 1'b0;
          cnt_d = '0;
        end
        LOOP_MANUAL:
          seen_d = persisted && code_now;
        LOOP_AUTO_UP:
          if (persisted && code_now)
          begin
            seen_d = 1'b1;
            loop_d = 1'b1;
            cnt_d = '0;
            state_d = LOOP_AUTO_DOWN;
          end
        LOOP_AUTO_DOWN:
          if (persisted && code_now)
          begin
            seen_d = 1'b0;
            loop_d = 1'b0;
            cnt_d = '0;
            state_d = LOOP_AUTO_UP;
          end
          else
            seen_d = 1'b1;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      state_q <= LOOP_OFF;
      cnt_q <= '0;
      mode_q <= `MODE_OFF;
      seen_q <= 1'b0;
      loop_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      mode_q <= mode_i;
      seen_q <= seen_d;
      loop_q <= loop_d;
    end
  end

  assign loop_code_seen_o = seen_q;
  assign remote_loop_o = loop_q;
endmodule

// ==== tb/liu_alarm_asserts.sv ====
// port checker for the alarm register block
`timescale 1ns/1ns
module liu_alarm_asserts #(
  parameter int unsigned CHANNELS = 8,
  parameter int unsigned PERSIST_CYCLES = 20
)
(
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [CHANNELS-1:0] driver_fault_i,
  input wire logic [CHANNELS-1:0] fifo_limit_i,
  input wire logic [CHANNELS-1:0] code_violation_i,
  input wire logic [CHANNELS-1:0] all_ones_seen_i,
  input wire logic [CHANNELS-1:0] signal_loss_i,
  input wire logic [CHANNELS-1:0] pattern_lock_i,
  input wire logic [CHANNELS-1:0] loop_up_code_i,
  input wire logic [CHANNELS-1:0] loop_down_code_i,
  input wire logic [7:0] rdata_o,
  input wire logic [CHANNELS-1:0] irq_o,
  input wire logic [CHANNELS-1:0] remote_loop_o,
  input wire logic [2*CHANNELS-1:0] rx_resistor_sel_o
);
  // =====
  // properties
  default clocking @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  property p_hold; !rd_i |=> $stable(rdata_o); endproperty
  a_hold: assert property (p_hold) else $error("read data moved");
  property p_unmap; rd_i && addr_i[7] |=> rdata_o == 8'h00; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read");
  // live byte is the detector two samples back: one for capture, one for read
  property p_live_hi; rd_i && addr_i == 8'h05 |=> rdata_o[7:4] ==
    {1'b0, $past(driver_fault_i[0], 2), $past(fifo_limit_i[0], 2),
    $past(code_violation_i[0], 2)}; endproperty
  a_live_hi: assert property (p_live_hi) else $error("live hi");
  property p_live_lo; rd_i && addr_i == 8'h05 |=> rdata_o[2:0] ==
    {$past(all_ones_seen_i[0], 2), $past(signal_loss_i[0], 2),
    $past(pattern_lock_i[0], 2)}; endproperty
  a_live_lo: assert property (p_live_lo) else $error("live lo");
  // resistor pins follow the register one cycle after it is written
  property p_res_wr; wr_i && addr_i == 8'h03 |=> ##1
    rx_resistor_sel_o[1:0] == $past(wdata_i[4:3], 2); endproperty
  a_res_wr: assert property (p_res_wr) else $error("resistor write");
  property p_res_hold; !wr_i |=> ##1 $stable(rx_resistor_sel_o); endproperty
  a_res_hold: assert property (p_res_hold) else $error("resistor moved");
  // loopback pin lags the timer decision by one register stage
  property p_lb_on; $rose(remote_loop_o[0]) |-> $past(loop_up_code_i[0], 2);
  endproperty
  a_lb_on: assert property (p_lb_on) else $error("loopback on");
  property p_lb_off; $fell(remote_loop_o[0]) |->
    $past(loop_down_code_i[0], 2) || $past(wr_i, 3); endproperty
  a_lb_off: assert property (p_lb_off) else $error("loopback off");
  c_chg: cover property (rd_i && addr_i[3:0] == 4'h6);
  c_irq: cover property ($rose(irq_o[1]));
  c_lb: cover property ($rose(remote_loop_o[0]));
endmodule
bind liu_channel_alarm_interrupt_regs liu_alarm_asserts #(
  .CHANNELS(CHANNELS), .PERSIST_CYCLES(PERSIST_CYCLES)) u_chk (
  .clk_i, .reset_n_i, .addr_i, .wdata_i, .wr_i, .rd_i, .driver_fault_i,
  .fifo_limit_i, .code_violation_i, .all_ones_seen_i, .signal_loss_i,
  .pattern_lock_i, .loop_up_code_i, .loop_down_code_i, .rdata_o, .irq_o,
  .remote_loop_o, .rx_resistor_sel_o);

// ==== tb/liu_host_model.sv ====
// host model for the parallel register port
`timescale 1ns/1ns
module liu_host_model (
  input wire logic clk_i,
  input wire logic [7:0] rdata_i,
  output logic [7:0] addr_o,
  output logic [7:0] wdata_o,
  output logic wr_o,
  output logic rd_o
);
  // =====
  // bus cycles, one strobe cycle each
  initial
  begin
    addr_o = 8'h00;
    wdata_o = 8'h00;
    wr_o = 1'b0;
    rd_o = 1'b0;
  end
  task automatic put(input logic [7:0] a, input logic [7:0] d, input logic w);
    @(negedge clk_i);
    addr_o = a;
    wdata_o = d;
    wr_o = w;
    rd_o = !w;
    @(negedge clk_i);
    wr_o = 1'b0;
    rd_o = 1'b0;
    // inverted leftovers so a stale address cannot pass for a held one
    addr_o = ~a;
    wdata_o = ~d;
  endtask
  task automatic get(input logic [7:0] a, output logic [7:0] d);
    put(a, 8'h00, 1'b0);
    d = rdata_i;
  endtask
endmodule

// ==== tb/test_liu_channel_alarm_interrupt_regs.sv ====
// self-checking bench for the alarm register block
`timescale 1ns/1ns
module test_liu_channel_alarm_interrupt_regs;
  logic clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic [7:0] addr, wdata, rdata, irq, rlb, df, fl, cv, ao, sl, pl, up, dn, v;
  logic [15:0] res;
  logic wr, rd;
  int failures = 0;
  int tests_run = 0;
  int cycles = 0;
  always #5 clk_i = ~clk_i;
  liu_host_model u_host (.clk_i, .rdata_i(rdata), .addr_o(addr),
    .wdata_o(wdata), .wr_o(wr), .rd_o(rd));
  liu_channel_alarm_interrupt_regs #(.PERSIST_CYCLES(20)) u_dut (.clk_i,
    .reset_n_i, .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd),
    .driver_fault_i(df), .fifo_limit_i(fl), .code_violation_i(cv),
    .all_ones_seen_i(ao), .signal_loss_i(sl), .pattern_lock_i(pl),
    .loop_up_code_i(up), .loop_down_code_i(dn), .rdata_o(rdata),
    .irq_o(irq), .remote_loop_o(rlb), .rx_resistor_sel_o(res));
  // =====
  // checking and closing
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      failures++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    u_host.get(a, v);
    chk(v, exp);
  endtask
  task automatic final_report();
    $display("checks %0d failures %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  always @(posedge clk_i)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      failures++;
      final_report();
    end
  end
  // =====
  // scenarios
  initial
  begin
    {df, fl, cv, ao, sl, pl, up, dn} = 64'h0;
    repeat (4) @(negedge clk_i);
    reset_n_i = 1'b1;
    for (int i = 3; i < 7; i++)
    begin
      rchk(8'(i), 8'h00);
      rchk(8'(8'h70 + i), 8'h00);
    end
    rchk(8'h80, 8'h00);
    u_host.put(8'h05, 8'hFF, 1'b1);
    rchk(8'h05, 8'h00);
    u_host.put(8'h14, 8'hFF, 1'b1);
    rchk(8'h14, 8'h7F);
    for (int r = 0; r < 4; r++)
    begin
      u_host.put(8'h03, 8'(r << 3), 1'b1);
      // the pins are a registered copy, one cycle behind the register
      @(negedge clk_i);
      chk({6'h0, res[1:0]}, 8'(r));
    end
    rchk(8'h03, 8'h18);
    df[1] = 1'b1;
    sl[1] = 1'b1;
    repeat (3) @(negedge clk_i);
    rchk(8'h15, 8'h42);
    chk(irq, 8'h02);
    rchk(8'h16, 8'h42);
    rchk(8'h16, 8'h00);
    chk(irq, 8'h00);
    df[1] = 1'b0;
    repeat (3) @(negedge clk_i);
    rchk(8'h16, 8'h40);
    u_host.put(8'h14, 8'h00, 1'b1);
    fl[1] = 1'b1;
    repeat (3) @(negedge clk_i);
    chk(irq, 8'h00);
    rchk(8'h16, 8'h20);
    {df[2], fl[2], cv[2], ao[2], sl[2], pl[2]} = 6'h3F;
    repeat (3) @(negedge clk_i);
    rchk(8'h25, 8'h77);
    // a change in the very cycle of the clearing read must survive it
    fork
      rchk(8'h16, 8'h00);
      begin
        @(negedge clk_i);
        pl[1] = 1'b1;
      end
    join
    rchk(8'h16, 8'h01);
    // modes off, up and down against each code; 30 cycles outlasts the shortened timer
    for (int m = 0; m < 3; m++)
      for (int c = 0; c < 2; c++)
      begin
        u_host.put(8'h03, 8'(m << 6), 1'b1);
        up[0] = (c == 0);
        dn[0] = (c == 1);
        repeat (30) @(negedge clk_i);
        rchk(8'h05, {4'h0, m == c + 1, 3'h0});
        {up[0], dn[0]} = 2'b00;
        repeat (3) @(negedge clk_i);
        rchk(8'h05, 8'h00);
      end
    u_host.put(8'h04, 8'h08, 1'b1);
    u_host.get(8'h06, v);
    u_host.put(8'h03, 8'hC0, 1'b1);
    rchk(8'h05, 8'h00);
    up[0] = 1'b1;
    repeat (10) @(negedge clk_i);
    chk(rlb, 8'h00);
    repeat (20) @(negedge clk_i);
    chk(rlb, 8'h01);
    chk(irq, 8'h01);
    up[0] = 1'b0;
    repeat (30) @(negedge clk_i);
    rchk(8'h05, 8'h08);
    dn[0] = 1'b1;
    repeat (30) @(negedge clk_i);
    chk(rlb, 8'h00);
    rchk(8'h06, 8'h08);
    rchk(8'h05, 8'h00);
    final_report();
  end
endmodule
